// ===== shared/adcr_pkg.sv
package adcr_pkg;
   // sub-addresses
   localparam logic [7:0] ADDR_VERSION = 8'h00;
   localparam logic [7:0] ADDR_IDENT = 8'h01;
   localparam logic [7:0] ADDR_CLKPLL = 8'h05;
   localparam logic [7:0] ADDR_PLLM = 8'h06;
   localparam logic [7:0] ADDR_PLLN = 8'h07;
   localparam logic [7:0] ADDR_REQPOL = 8'h0C;
   localparam logic [7:0] ADDR_SCKPOL = 8'h0D;
   localparam logic [7:0] ADDR_ERROR = 8'h0F;
   localparam logic [7:0] ADDR_SRESET = 8'h10;
   localparam logic [7:0] ADDR_PLAY = 8'h13;
   localparam logic [7:0] ADDR_MUTE = 8'h14;
   localparam logic [7:0] ADDR_ANCCMD = 8'h16;
   localparam logic [7:0] ADDR_PINSEL = 8'h18;
   localparam logic [7:0] ADDR_SYNC = 8'h40;
   localparam logic [7:0] ADDR_ANCL = 8'h41;
   localparam logic [7:0] ADDR_ANCH = 8'h42;
   localparam logic [7:0] ADDR_ADPCM_FIRST = 8'h40;
   localparam logic [7:0] ADDR_ADPCM_LAST = 8'h51;
   localparam logic [7:0] ADDR_ANCBUF_FIRST = 8'h7E;
   localparam logic [7:0] ADDR_ANCBUF_LAST = 8'hB5;
   // buffer depths
   localparam int ADPCM_DEPTH = 18;
   localparam int ANCBUF_DEPTH = 56;
   // clock/pll control field positions
   localparam int CP_FRAC = 0;
   localparam int CP_XTAL_X = 1;
   localparam int CP_XTAL_S = 2;
   localparam int CP_VCO_DIS = 3;
   localparam int CP_SYS_OUTPUT_CLOCK_PIN = 4;
   localparam int CP_OUTPUT_CLOCK_PIN_EN = 5;
   localparam int CP_XTO_DIS = 6;
   localparam int CP_SHARED_EN = 7;
   localparam int REQPOL_INV_BIT = 2;
   localparam int SCK_FALL_BIT = 2;
   localparam int PINSEL_REQ_BIT = 2;
   // reset values (hardware / software)
   localparam logic [7:0] CLKPLL_RST = 8'hA1;
   localparam logic [7:0] PLLM_RST = 8'h0C;
   localparam logic [7:0] PLLN_RST = 8'h00;
   localparam logic [7:0] REQPOL_HW_RST = 8'h00;
   localparam logic [7:0] REQPOL_SW_RST = 8'h01;
   localparam logic [7:0] SCKPOL_RST = 8'h04;
   localparam logic [7:0] PLAY_RST = 8'h01;
   localparam logic [7:0] ZERO_RST = 8'h00;
   // writable bit masks, all other bits read zero
   localparam logic [7:0] REQPOL_MASK = 8'h05;
   localparam logic [7:0] SCKPOL_MASK = 8'h04;
   localparam logic [7:0] BIT0_MASK = 8'h01;
   localparam logic [7:0] PINSEL_MASK = 8'h04;
   localparam logic [7:0] ERR_MASK = 8'h3F;
   // identification, arbitrary values
   localparam logic [7:0] VERSION_CODE = 8'h11;
   localparam logic [7:0] IDENT_CODE = 8'h5A;
endpackage

// ===== src/adcr_regs.sv
// Functional notes
// - sub-address 0x00 reads a fixed chip version byte.
// - sub-address 0x01 reads a fixed identity byte, reset never alters it.
// - clock/pll bit 0 loads the pll fraction into the switching circuit.
// - bits 1 and 2 pick crystal over vco for dividers x and s.
// - bit 3 disables the vco output.
// - bit 4 drives output clock at system clock rate for test.
// - bit 5 enables output clock pad, bit 6 disables crystal out pad.
// - bit 7 enables the shared buffered-clock / data-request pin.
// - request polarity 0x01 means high requests, bit 2 inverts to low.
// - clock polarity 0x00 samples rising edge, 0x04 samples falling edge.
// - error register keeps last six-bit error code, zero after reset unless an error coincides with soft reset.
// - any write to 0x10 soft resets command, interrupt and decoder.
// - play bit resets to one and acts only in decode state.
// - mute bit resets to zero and starts the output clock.
// - nonzero write to 0x16 makes device refill ancillary buffer 0x7E-0xB5.
// - pin select bit 2 chooses buffered clock or data request on shared pin.
// - buffered clock on shared pin follows crystal input frequency.
// - sync register bits 1:0 report synchroniser state.
// - in adpcm mode 0x40-0x51 is a read/write encoded data buffer.
// - ancillary count low and high bytes form a sixteen-bit count.
`timescale 1ns/1ns
module adcr_regs
   import adcr_pkg::*;
#(
   parameter logic [7:0] VERSION_VALUE = VERSION_CODE, // arbitrary value
   parameter logic [7:0] IDENT_VALUE = IDENT_CODE // arbitrary value
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic ADPCM_MODE,
   input wire logic DECODE_STATE,
   input wire logic [1:0] SYNC_STATE,
   input wire logic ERR_EVENT,
   input wire logic [5:0] ERR_CODE,
   input wire logic ANC_COUNT_LOAD,
   input wire logic [15:0] ANC_COUNT,
   input wire logic ANC_WR,
   input wire logic [5:0] ANC_WR_INDEX,
   input wire logic [7:0] ANC_WR_DATA,
   input wire logic ANC_DONE,
   input wire logic [4:0] ADPCM_RD_INDEX,
   output logic [7:0] ADPCM_RD_DATA,
   input wire logic CRYSTAL_INPUT,
   input wire logic DATA_REQUEST_IN,
   output logic FRACTION_UPDATE,
   output logic CRYSTAL_TO_DIVIDER_X,
   output logic CRYSTAL_TO_DIVIDER_S,
   output logic VCO_OUTPUT_DISABLE,
   output logic SYSTEM_CLOCK_TO_CLOCK_OUT,
   output logic CLOCK_OUT_PAD_ENABLE,
   output logic CRYSTAL_OUT_PAD_DISABLE,
   output logic [7:0] PLL_MULTIPLIER,
   output logic [7:0] PLL_INPUT_DIVIDER,
   output logic REQUEST_ACTIVE_LOW,
   output logic SERIAL_SAMPLE_FALLING,
   output logic PLAY_ACTIVE,
   output logic MUTE_ACTIVE,
   output logic CLOCK_RUN,
   output logic ANC_CAPTURE_REQ,
   output logic SOFT_RESET_PULSE,
   output logic SHARED_PIN_OUT,
   output logic SHARED_PIN_OE
);

default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (!RST_B);

////////////////////////////////////////////////////////////////////////////////
// decode

logic wr_clkpll, wr_pllm, wr_plln, wr_reqpol, wr_sckpol;
logic wr_play, wr_mute, wr_anccmd, wr_pinsel, soft_rst;
logic in_adpcm, in_ancbuf;
logic [4:0] adp_idx;
logic [5:0] anc_idx;

assign in_adpcm = ADPCM_MODE && (REG_ADDR >= ADDR_ADPCM_FIRST)
   && (REG_ADDR <= ADDR_ADPCM_LAST);
assign in_ancbuf = (REG_ADDR >= ADDR_ANCBUF_FIRST) && (REG_ADDR <= ADDR_ANCBUF_LAST);
assign adp_idx = 5'(REG_ADDR - ADDR_ADPCM_FIRST);
assign anc_idx = 6'(REG_ADDR - ADDR_ANCBUF_FIRST);
// read-only and unmapped addresses simply produce no strobe
assign wr_clkpll = REG_WR && (REG_ADDR == ADDR_CLKPLL);
assign wr_pllm = REG_WR && (REG_ADDR == ADDR_PLLM);
assign wr_plln = REG_WR && (REG_ADDR == ADDR_PLLN);
assign wr_reqpol = REG_WR && (REG_ADDR == ADDR_REQPOL);
assign wr_sckpol = REG_WR && (REG_ADDR == ADDR_SCKPOL);
assign wr_play = REG_WR && (REG_ADDR == ADDR_PLAY);
assign wr_mute = REG_WR && (REG_ADDR == ADDR_MUTE);
assign wr_anccmd = REG_WR && (REG_ADDR == ADDR_ANCCMD);
assign wr_pinsel = REG_WR && (REG_ADDR == ADDR_PINSEL);
assign soft_rst = REG_WR && (REG_ADDR == ADDR_SRESET);

////////////////////////////////////////////////////////////////////////////////
// control registers; soft reset reloads the software reset values, except clock run and an error code arriving in that cycle

logic [7:0] clkpll_q, pllm_q, plln_q, reqpol_q, sckpol_q;
logic [7:0] play_q, mute_q, pinsel_q, err_q;
logic anccmd_q, anc_req_q, clock_run_q, soft_pulse_q;
logic [15:0] anc_count_q;

always_ff @(posedge CLK_SYS) begin
   if (!RST_B || soft_rst) begin
      clkpll_q <= CLKPLL_RST;
   end else if (wr_clkpll) begin
      clkpll_q <= REG_WDATA;
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B || soft_rst) begin
      pllm_q <= PLLM_RST;
      plln_q <= PLLN_RST;
   end else begin
      if (wr_pllm) begin
         pllm_q <= REG_WDATA;
      end
      if (wr_plln) begin
         plln_q <= REG_WDATA;
      end
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      reqpol_q <= REQPOL_HW_RST;
   end else if (soft_rst) begin
      reqpol_q <= REQPOL_SW_RST;
   end else if (wr_reqpol) begin
      reqpol_q <= REG_WDATA & REQPOL_MASK;
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B || soft_rst) begin
      sckpol_q <= SCKPOL_RST;
   end else if (wr_sckpol) begin
      sckpol_q <= REG_WDATA & SCKPOL_MASK;
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B || soft_rst) begin
      play_q <= PLAY_RST;
      mute_q <= ZERO_RST;
      pinsel_q <= ZERO_RST;
   end else begin
      if (wr_play) begin
         play_q <= REG_WDATA & BIT0_MASK;
      end
      if (wr_mute) begin
         mute_q <= REG_WDATA & BIT0_MASK;
      end
      if (wr_pinsel) begin
         pinsel_q <= REG_WDATA & PINSEL_MASK;
      end
   end
end

// clock keeps running once mute has started it; only a hardware reset stops it
always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      clock_run_q <= 1'b0;
   end else if (wr_mute && REG_WDATA[0]) begin
      clock_run_q <= 1'b1;
   end
end

// last error wins; an event in the soft reset cycle is kept
always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      err_q <= ZERO_RST;
   end else if (ERR_EVENT) begin
      err_q <= {2'h0, ERR_CODE};
   end else if (soft_rst) begin
      err_q <= ZERO_RST;
   end
end

// capture command: set on nonzero write, cleared by soft reset, engine done or a zero write
always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      anccmd_q <= 1'b0;
   end else if (wr_anccmd && (REG_WDATA != ZERO_RST)) begin
      anccmd_q <= 1'b1;
   end else if (soft_rst || ANC_DONE || wr_anccmd) begin
      anccmd_q <= 1'b0;
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      anc_req_q <= 1'b0;
      soft_pulse_q <= 1'b0;
   end else begin
      anc_req_q <= wr_anccmd && (REG_WDATA != ZERO_RST);
      soft_pulse_q <= soft_rst;
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B || soft_rst) begin
      anc_count_q <= 16'h0000;
   end else if (ANC_COUNT_LOAD) begin
      anc_count_q <= ANC_COUNT;
   end
end

////////////////////////////////////////////////////////////////////////////////
// buffers: adpcm_encoded_buffer (host side) and ancillary data (engine side)

logic [7:0] adpcm_q [ADPCM_DEPTH];
logic [7:0] ancbuf_q [ANCBUF_DEPTH];

genvar gi;
generate
   for (gi = 0; gi < ADPCM_DEPTH; gi++) begin : g_adpcm
      always_ff @(posedge CLK_SYS) begin
         if (!RST_B || soft_rst) begin
            adpcm_q[gi] <= ZERO_RST;
         end else if (REG_WR && in_adpcm && (adp_idx == 5'(gi))) begin
            adpcm_q[gi] <= REG_WDATA;
         end
      end
   end
   for (gi = 0; gi < ANCBUF_DEPTH; gi++) begin : g_anc
      always_ff @(posedge CLK_SYS) begin
         if (!RST_B || soft_rst) begin
            ancbuf_q[gi] <= ZERO_RST;
         end else if (ANC_WR && (ANC_WR_INDEX == 6'(gi))) begin
            ancbuf_q[gi] <= ANC_WR_DATA;
         end
      end
   end
endgenerate

always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      ADPCM_RD_DATA <= ZERO_RST;
   end else if (ADPCM_RD_INDEX < 5'(ADPCM_DEPTH)) begin
      ADPCM_RD_DATA <= adpcm_q[ADPCM_RD_INDEX];
   end else begin
      ADPCM_RD_DATA <= ZERO_RST;
   end
end

////////////////////////////////////////////////////////////////////////////////
// read path, one cycle latency, unmapped reads give zero

logic [7:0] rd_d;

always_comb begin
   rd_d = ZERO_RST;
   if (in_adpcm) begin
      rd_d = adpcm_q[adp_idx];
   end else if (in_ancbuf) begin
      rd_d = ancbuf_q[anc_idx];
   end else if (REG_ADDR == ADDR_VERSION) begin
      rd_d = VERSION_VALUE;
   end else if (REG_ADDR == ADDR_IDENT) begin
      rd_d = IDENT_VALUE;
   end else if (REG_ADDR == ADDR_CLKPLL) begin
      rd_d = clkpll_q;
   end else if (REG_ADDR == ADDR_PLLM) begin
      rd_d = pllm_q;
   end else if (REG_ADDR == ADDR_PLLN) begin
      rd_d = plln_q;
   end else if (REG_ADDR == ADDR_REQPOL) begin
      rd_d = reqpol_q;
   end else if (REG_ADDR == ADDR_SCKPOL) begin
      rd_d = sckpol_q;
   end else if (REG_ADDR == ADDR_ERROR) begin
      rd_d = err_q & ERR_MASK;
   end else if (REG_ADDR == ADDR_PLAY) begin
      rd_d = play_q;
   end else if (REG_ADDR == ADDR_MUTE) begin
      rd_d = mute_q;
   end else if (REG_ADDR == ADDR_ANCCMD) begin
      rd_d = {7'h00, anccmd_q};
   end else if (REG_ADDR == ADDR_PINSEL) begin
      rd_d = pinsel_q;
   end else if (REG_ADDR == ADDR_SYNC) begin
      rd_d = {6'h00, SYNC_STATE};
   end else if (REG_ADDR == ADDR_ANCL) begin
      rd_d = anc_count_q[7:0];
   end else if (REG_ADDR == ADDR_ANCH) begin
      rd_d = anc_count_q[15:8];
   end
end

always_ff @(posedge CLK_SYS) begin
   if (!RST_B) begin
      REG_RDATA <= ZERO_RST;
      REG_RVALID <= 1'b0;
   end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
         REG_RDATA <= rd_d;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign FRACTION_UPDATE = clkpll_q[CP_FRAC];
assign CRYSTAL_TO_DIVIDER_X = clkpll_q[CP_XTAL_X];
assign CRYSTAL_TO_DIVIDER_S = clkpll_q[CP_XTAL_S];
assign VCO_OUTPUT_DISABLE = clkpll_q[CP_VCO_DIS];
assign SYSTEM_CLOCK_TO_CLOCK_OUT = clkpll_q[CP_SYS_OUTPUT_CLOCK_PIN];
assign CLOCK_OUT_PAD_ENABLE = clkpll_q[CP_OUTPUT_CLOCK_PIN_EN];
assign CRYSTAL_OUT_PAD_DISABLE = clkpll_q[CP_XTO_DIS];
assign PLL_MULTIPLIER = pllm_q;
assign PLL_INPUT_DIVIDER = plln_q;
assign REQUEST_ACTIVE_LOW = reqpol_q[REQPOL_INV_BIT];
assign SERIAL_SAMPLE_FALLING = sckpol_q[SCK_FALL_BIT];
assign PLAY_ACTIVE = play_q[0] && DECODE_STATE;
assign MUTE_ACTIVE = mute_q[0];
assign CLOCK_RUN = clock_run_q;
assign ANC_CAPTURE_REQ = anc_req_q;
assign SOFT_RESET_PULSE = soft_pulse_q;
// clock path is a plain mux so the crystal rate passes undivided
assign SHARED_PIN_OE = clkpll_q[CP_SHARED_EN];
assign SHARED_PIN_OUT = !SHARED_PIN_OE ? 1'b0
   : pinsel_q[PINSEL_REQ_BIT] ? (DATA_REQUEST_IN ^ reqpol_q[REQPOL_INV_BIT])
   : CRYSTAL_INPUT;

////////////////////////////////////////////////////////////////////////////////
// checks

sequence s_soft_write;
   REG_WR && (REG_ADDR == ADDR_SRESET);
endsequence

sequence s_soft_state;
   clkpll_q == CLKPLL_RST && play_q == PLAY_RST && reqpol_q == REQPOL_SW_RST
      && !anccmd_q && mute_q == ZERO_RST;
endsequence

a_soft_reset_reload: assert property (
   s_soft_write |=> s_soft_state ##0 SOFT_RESET_PULSE)
   else $error("soft reset did not reload registers");

a_ident_fixed: assert property (
   REG_RD && REG_ADDR == ADDR_IDENT |=> REG_RVALID && REG_RDATA == IDENT_VALUE)
   else $error("identity read wrong");

a_play_gate: assert property (
   wr_play && !soft_rst ##1 DECODE_STATE |-> PLAY_ACTIVE == $past(REG_WDATA[0]))
   else $error("play request not applied in decode state");

a_error_latch: assert property (
   ERR_EVENT |=> err_q == {2'h0, $past(ERR_CODE)} ##1 ($stable(err_q) || $past(ERR_EVENT)
      || $past(soft_rst)))
   else $error("error code not latched or not held");

a_mute_clock: assert property (
   wr_mute && REG_WDATA[0] && !soft_rst |=> MUTE_ACTIVE && CLOCK_RUN)
   else $error("mute did not start clock");

a_capture_req: assert property (
   wr_anccmd && REG_WDATA != ZERO_RST |=> ANC_CAPTURE_REQ ##1 !ANC_CAPTURE_REQ)
   else $error("capture request not a single pulse");

a_pin_clock: assert property (
   SHARED_PIN_OE && !pinsel_q[PINSEL_REQ_BIT] |-> SHARED_PIN_OUT == CRYSTAL_INPUT)
   else $error("shared pin does not follow crystal");

a_reqpol_zero: assert property (
   wr_reqpol && !soft_rst |=> (reqpol_q & ~REQPOL_MASK) == ZERO_RST
      && reqpol_q[0] == $past(REG_WDATA[0]))
   else $error("request polarity don't-care bits stored");

a_sync_read: assert property (
   REG_RD && REG_ADDR == ADDR_SYNC && !ADPCM_MODE
      |=> REG_RDATA == {6'h00, $past(SYNC_STATE)})
   else $error("sync state read wrong");

a_adpcm_rw: assert property (
   REG_WR && in_adpcm && !soft_rst ##2 REG_RD && ADPCM_MODE && !$past(REG_WR)
      && REG_ADDR == $past(REG_ADDR, 2) |=> REG_RDATA == $past(REG_WDATA, 3))
   else $error("adpcm buffer readback wrong");

endmodule

// ===== tb/adcr_host.sv
`timescale 1ns/1ns
module adcr_host (
   input wire logic clk,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // callers pass documented, writable sub-addresses only; pll m/n are read, never written
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      // released bus must not keep the old byte
      addr = ~a;
      wdata = ~d;
   endtask
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      d = rdata;
      v = rvalid;
   endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import adcr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, adpcm_rd_data, anc_wr_data, pll_m, pll_n, rd_val;
   logic reg_wr, reg_rd, reg_rvalid, adpcm_mode, decode_state, err_event, anc_count_load;
   logic anc_wr, anc_done, crystal_input, data_request_in, rd_ok;
   logic [1:0] sync_state;
   logic [5:0] err_code, anc_wr_index;
   logic [15:0] anc_count;
   logic [4:0] adpcm_rd_index;
   logic [6:0] cp_bits;
   logic req_low, sck_fall, play_active, mute_active, clock_run, anc_req, soft_pulse;
   logic pin_out, pin_oe;
   int n_mismatch = 0;
   int checks = 0;

   always #2 clk_sys = ~clk_sys;

   adcr_regs dut (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .ADPCM_MODE(adpcm_mode), .DECODE_STATE(decode_state), .SYNC_STATE(sync_state),
      .ERR_EVENT(err_event), .ERR_CODE(err_code), .ANC_COUNT_LOAD(anc_count_load),
      .ANC_COUNT(anc_count), .ANC_WR(anc_wr), .ANC_WR_INDEX(anc_wr_index),
      .ANC_WR_DATA(anc_wr_data), .ANC_DONE(anc_done), .ADPCM_RD_INDEX(adpcm_rd_index),
      .ADPCM_RD_DATA(adpcm_rd_data), .CRYSTAL_INPUT(crystal_input),
      .DATA_REQUEST_IN(data_request_in), .FRACTION_UPDATE(cp_bits[0]),
      .CRYSTAL_TO_DIVIDER_X(cp_bits[1]), .CRYSTAL_TO_DIVIDER_S(cp_bits[2]),
      .VCO_OUTPUT_DISABLE(cp_bits[3]), .SYSTEM_CLOCK_TO_CLOCK_OUT(cp_bits[4]),
      .CLOCK_OUT_PAD_ENABLE(cp_bits[5]), .CRYSTAL_OUT_PAD_DISABLE(cp_bits[6]),
      .PLL_MULTIPLIER(pll_m), .PLL_INPUT_DIVIDER(pll_n), .REQUEST_ACTIVE_LOW(req_low),
      .SERIAL_SAMPLE_FALLING(sck_fall), .PLAY_ACTIVE(play_active), .MUTE_ACTIVE(mute_active),
      .CLOCK_RUN(clock_run), .ANC_CAPTURE_REQ(anc_req), .SOFT_RESET_PULSE(soft_pulse),
      .SHARED_PIN_OUT(pin_out), .SHARED_PIN_OE(pin_oe)
   );

   adcr_host host (.clk(clk_sys), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
      .wdata(reg_wdata), .rdata(reg_rdata), .rvalid(reg_rvalid));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd_byte(a, rd_val, rd_ok);
      chk($sformatf("rvalid %h", a), 8'h01, {7'h00, rd_ok});
      chk($sformatf("reg %h", a), exp, rd_val);
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk_sys);
      #1;
      s = 1'b1;
      @(posedge clk_sys);
      #1;
      s = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rchk(ADDR_VERSION, VERSION_CODE);
      rchk(ADDR_IDENT, IDENT_CODE);
      rchk(ADDR_CLKPLL, 8'hA1);
      chk("clkpll outs", 8'h21, {1'b0, cp_bits});
      chk("shared oe", 8'h01, {7'h00, pin_oe});
      rchk(ADDR_PLLM, 8'h0C);
      rchk(ADDR_PLLN, 8'h00);
      chk("pll m out", 8'h0C, pll_m);
      chk("pll n out", 8'h00, pll_n);
      chk("sck fall rst", 8'h01, {7'h00, sck_fall});
      rchk(ADDR_REQPOL, 8'h00);
      rchk(ADDR_SCKPOL, 8'h04);
      rchk(ADDR_ERROR, 8'h00);
      rchk(ADDR_PLAY, 8'h01);
      rchk(ADDR_MUTE, 8'h00);
      rchk(ADDR_ANCCMD, 8'h00);
      rchk(ADDR_PINSEL, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_masks();
      logic [7:0] a[5] = '{ADDR_REQPOL, ADDR_SCKPOL, ADDR_SCKPOL, ADDR_PLAY, ADDR_PINSEL};
      logic [7:0] w[5] = '{8'hFF, 8'hFF, 8'h00, 8'hFE, 8'hFF};
      logic [7:0] e[5] = '{8'h05, 8'h04, 8'h00, 8'h00, 8'h04};
      for (int i = 0; i < 5; i++) begin
         host.wr_byte(a[i], w[i]);
         rchk(a[i], e[i]);
      end
      chk("req low", 8'h01, {7'h00, req_low});
      chk("sck fall", 8'h00, {7'h00, sck_fall});
      host.wr_byte(ADDR_PLAY, 8'h01);
      $display("test masks done");
   endtask
   task automatic t_clkpll();
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         host.wr_byte(ADDR_CLKPLL, v);
         rchk(ADDR_CLKPLL, v);
         chk("clkpll outs", {1'b0, v[6:0]}, {1'b0, cp_bits});
         chk("shared oe", {7'h00, v[7]}, {7'h00, pin_oe});
      end
      $display("test clock control done");
   endtask
   task automatic t_pin();
      host.wr_byte(ADDR_CLKPLL, 8'hA1);
      host.wr_byte(ADDR_REQPOL, 8'h01);
      host.wr_byte(ADDR_PINSEL, 8'h00);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         #1;
         crystal_input = i[0];
         #1;
         chk("pin clock", {7'h00, i[0]}, {7'h00, pin_out});
      end
      host.wr_byte(ADDR_PINSEL, 8'h04);
      data_request_in = 1'b1;
      #1;
      chk("pin req high", 8'h01, {7'h00, pin_out});
      host.wr_byte(ADDR_REQPOL, 8'h05);
      chk("pin req low", 8'h00, {7'h00, pin_out});
      $display("test shared pin done");
   endtask
   task automatic t_play_mute();
      decode_state = 1'b0;
      #1;
      chk("play idle", 8'h00, {7'h00, play_active});
      @(posedge clk_sys);
      #1;
      decode_state = 1'b1;
      #1;
      chk("play decode", 8'h01, {7'h00, play_active});
      host.wr_byte(ADDR_PLAY, 8'h00);
      chk("play off", 8'h00, {7'h00, play_active});
      host.wr_byte(ADDR_PLAY, 8'h01);
      chk("play on", 8'h01, {7'h00, play_active});
      host.wr_byte(ADDR_MUTE, 8'h01);
      chk("mute clock", 8'h03, {6'h00, mute_active, clock_run});
      host.wr_byte(ADDR_MUTE, 8'h00);
      rchk(ADDR_MUTE, 8'h00);
      chk("clock run kept", 8'h01, {7'h00, clock_run});
      $display("test play mute done");
   endtask
   task automatic t_anc();
      host.wr_byte(ADDR_ANCCMD, 8'h02);
      chk("capture req", 8'h01, {7'h00, anc_req});
      rchk(ADDR_ANCCMD, 8'h01);
      anc_wr_index = 6'd0;
      anc_wr_data = 8'h3C;
      pulse(anc_wr);
      anc_wr_index = 6'd55;
      anc_wr_data = 8'hC3;
      pulse(anc_wr);
      rchk(ADDR_ANCBUF_FIRST, 8'h3C);
      rchk(ADDR_ANCBUF_LAST, 8'hC3);
      pulse(anc_done);
      rchk(ADDR_ANCCMD, 8'h00);
      anc_count = 16'h1234;
      pulse(anc_count_load);
      rchk(ADDR_ANCL, 8'h34);
      rchk(ADDR_ANCH, 8'h12);
      $display("test ancillary done");
   endtask
   task automatic t_soft();
      err_code = 6'h2A;
      pulse(err_event);
      rchk(ADDR_ERROR, 8'h2A);
      host.wr_byte(ADDR_CLKPLL, 8'h00);
      host.wr_byte(ADDR_ANCCMD, 8'h01);
      host.wr_byte(ADDR_SRESET, 8'h00);
      chk("soft pulse", 8'h01, {7'h00, soft_pulse});
      chk("clock run soft", 8'h01, {7'h00, clock_run});
      rchk(ADDR_IDENT, IDENT_CODE);
      rchk(ADDR_ANCCMD, 8'h00);
      rchk(ADDR_REQPOL, 8'h01);
      rchk(ADDR_CLKPLL, 8'hA1);
      rchk(ADDR_ERROR, 8'h00);
      $display("test soft reset done");
   endtask
   task automatic t_adpcm();
      sync_state = 2'b10;
      rchk(ADDR_SYNC, 8'h02);
      adpcm_mode = 1'b1;
      host.wr_byte(ADDR_ADPCM_FIRST, 8'h5A);
      rchk(ADDR_ADPCM_FIRST, 8'h5A);
      host.wr_byte(ADDR_ADPCM_LAST, 8'hA5);
      rchk(ADDR_ADPCM_LAST, 8'hA5);
      adpcm_rd_index = 5'd17;
      @(posedge clk_sys);
      #1;
      chk("adpcm engine", 8'hA5, adpcm_rd_data);
      $display("test adpcm done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      {adpcm_mode, decode_state, err_event, anc_count_load, anc_wr, anc_done} = 6'h00;
      {crystal_input, data_request_in, sync_state, err_code, anc_wr_index} = 16'h0000;
      anc_count = 16'h0000;
      anc_wr_data = 8'h00;
      adpcm_rd_index = 5'd0;
      repeat (20) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_masks();
      t_clkpll();
      t_pin();
      t_play_mute();
      t_anc();
      t_soft();
      t_adpcm();
      complete_run();
   end
   // whole run is under two hundred cycles; allow ten thousand
   initial begin
      #40000;
      n_mismatch++;
      complete_run();
   end
endmodule
